// *** pkg/rft_pkg.sv ***
// Package with register map, field layouts, timing counts and carriers
package rft_pkg;
  // Register byte offsets on the APB port
  localparam logic [7:0] RFT_CTRL_OFS = 8'h00;
  localparam logic [7:0] RFT_FOFS_OFS = 8'h04;
  localparam logic [7:0] RFT_COFS_OFS = 8'h08;
  localparam logic [7:0] RFT_DFLT_OFS = 8'h0C;
  localparam logic [7:0] RFT_SCCO_OFS = 8'h10;
  localparam logic [7:0] RFT_MEAS_OFS = 8'h14;
  localparam logic [7:0] RFT_TBS_OFS = 8'h18;
  localparam logic [7:0] RFT_STAT_OFS = 8'h1C;
  localparam logic [7:0] RFT_DCHO_OFS = 8'h20;
  // Control register fields
  localparam int RFT_CTRL_RUN_BIT = 0;
  localparam int RFT_CTRL_PCH_BIT = 1;
  localparam int RFT_CTRL_ONE_BIT = 2;
  // Default offset register fields
  localparam int RFT_DFLT_TDD_LSB = 16;
  // Measurement register fields
  localparam int RFT_MEAS_CHIP_LSB = 16;
  // Status register fields
  localparam int RFT_STAT_BUSY_BIT = 16;
  localparam int RFT_STAT_ERR_BIT = 17;
  localparam int RFT_STAT_CFN_LSB = 20;
  // Reset values
  localparam logic [2:0] RFT_CTRL_RST = 3'h0;
  localparam logic [15:0] RFT_ZERO16 = 16'h0000;
  // Counter ranges and offset limits
  localparam logic [11:0] RFT_LONG_MAX = 12'hFFF;
  localparam logic [11:0] RFT_CONN_MAX = 12'h0FF;
  localparam logic [15:0] RFT_CHIP_MAX = 16'h95FF;
  localparam logic [15:0] RFT_CHIPS_PER_FRAME = 16'h9600;
  localparam logic [9:0] RFT_FDD_DFLT_MAX = 10'h257;
  localparam logic [7:0] RFT_HALF_STEP = 8'h80;
  // Frame period and clock rate
  localparam int RFT_FRAME_US = 10000;
  localparam int RFT_CLK_KHZ = 40000;
  localparam int RFT_FRAME_CYC = RFT_FRAME_US * RFT_CLK_KHZ / 1000;
  // Secondary common channel offset codes: 0, 10, 20 or 40 ms
  typedef enum logic [1:0] {
    RFT_SCC_0MS,
    RFT_SCC_10MS,
    RFT_SCC_20MS,
    RFT_SCC_40MS
  } rft_scc_e;
  // Offsets presented to the device
  typedef struct packed {
    logic [7:0] link_frame_offset;
    logic [15:0] link_chip_offset;
    logic [15:0] dedicated_channel_frame_offset;
    logic [9:0] fdd_default_link_offset;
    logic [2:0] tdd_default_link_offset;
    rft_scc_e secondary_common_channel_offset;
  } rft_offsets_s;
  // Terminal measurements forwarded to the device
  typedef struct packed {
    logic [7:0] measured_frame_difference;
    logic [15:0] measured_chip_difference;
  } rft_meas_s;
  // Transport block set announcement
  typedef struct packed {
    logic [11:0] connection_frame_counter;
    logic [15:0] tag;
  } rft_tbs_s;
endpackage

// *** rtl/rft_frame_ctr.sv ***
// Wrapping frame counter with a run-time maximum
`timescale 1ns/1ps
module rft_frame_ctr
  import rft_pkg::*;
#(
  parameter int W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic [W-1:0] max_val,
  output logic [W-1:0] count
);
  logic [W-1:0] count_q;

  generate
    if (W < 8) begin : g_chk
      $error("rft_frame_ctr: width below 8 cannot hold the ranges");
    end
  endgenerate

  // One step per frame tick, wrap after the maximum
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= '0;
    end else if (tick) begin
      if (count_q >= max_val) begin
        count_q <= '0;
      end else begin
        count_q <= count_q + 1'b1;
      end
    end
  end

  assign count = count_q;
endmodule

// *** rtl/rft_round256.sv ***
// Rounds a chip offset to the nearest 256-chip boundary within a frame
`timescale 1ns/1ps
module rft_round256
  import rft_pkg::*;
(
  input wire logic [15:0] chips,
  output logic [15:0] rounded
);
  logic [16:0] up;

  // Low byte of 128 or more rounds up; a whole frame folds back to zero
  always_comb begin
    up = {1'b0, chips[15:8], 8'h00} + 17'h00100;
    if (chips[7:0] >= RFT_HALF_STEP) begin
      if (up[15:0] >= RFT_CHIPS_PER_FRAME) begin
        rounded = RFT_ZERO16;
      end else begin
        rounded = up[15:0];
      end
    end else begin
      rounded = {chips[15:8], 8'h00};
    end
  end
endmodule

// *** rtl/rft_ctrl.sv ***
// Controller that keeps its frame timebase and supplies offsets to the base station
//
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
// Behaviour
// - Controller keeps own frame counter 0..4095
// - Connection counter 0..255, paging 0..4095
// - Every transport block set carries connection number
// - Link frame offset 0..255, one frame steps
// - Measured frame difference 0..255
// - Single link from common: frame difference zero
// - FDD default offset 0..599, 512-chip units
// - TDD default offset 0..7 frames
// - Link chip offset 0..38399, given to station
// - Dedicated offset is chip offset rounded, 256 steps
// - Measured chip difference 0..38399
// - Single link from common: chip difference zero
module rft_ctrl
  import rft_pkg::*;
#(
  parameter int FRAME_CYC = RFT_FRAME_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output rft_offsets_s offsets,
  output rft_meas_s meas,
  output logic frame_tick,
  output logic tbs_valid,
  output rft_tbs_s tbs,
  input wire logic tbs_ready
);
  typedef enum logic {
    RFT_TB_IDLE,
    RFT_TB_SEND
  } rft_tb_e;

  localparam int TW = $clog2(FRAME_CYC);

  generate
    if (FRAME_CYC < 2) begin : g_chk
      $error("rft_ctrl: FRAME_CYC must be at least 2");
    end
  endgenerate

  // Decodes which word offsets exist
  function automatic logic rft_mapped(input logic [7:0] a);
    case (a)
      RFT_CTRL_OFS, RFT_FOFS_OFS, RFT_COFS_OFS, RFT_DFLT_OFS,
      RFT_SCCO_OFS, RFT_MEAS_OFS, RFT_TBS_OFS, RFT_STAT_OFS,
      RFT_DCHO_OFS: rft_mapped = 1'b1;
      default: rft_mapped = 1'b0;
    endcase
  endfunction

  logic setup;
  logic access;
  logic wr;
  logic [2:0] ctrl_q;
  logic [7:0] fofs_q;
  logic [15:0] cofs_q;
  logic [9:0] fdd_q;
  logic [2:0] tdd_q;
  rft_scc_e scc_q;
  logic [7:0] mfd_q;
  logic [15:0] mcd_q;
  logic err_q;
  logic err_set;
  logic err_clr;
  logic [31:0] prdata_q;
  logic [31:0] rd_d;
  logic [TW-1:0] div_q;
  logic tick;
  logic [11:0] ctl_cnt;
  logic [11:0] conn_cnt;
  logic [11:0] conn_max;
  logic [15:0] dch_rnd;
  logic [15:0] dch_q;
  rft_tb_e tb_q;
  rft_tbs_s tbs_q;
  rft_meas_s meas_q;
  logic cofs_bad;
  logic fdd_bad;

  // Zero-wait slave; read data is latched in the setup cycle
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign wr = access & pwrite;
  assign pready = 1'b1;
  assign pslverr = access & ~rft_mapped(paddr);
  assign prdata = prdata_q;

  // Range checks on software values before they reach the station
  assign cofs_bad = pwdata[15:0] > RFT_CHIP_MAX;
  assign fdd_bad = pwdata[9:0] > RFT_FDD_DFLT_MAX;

  // Control register steers the timebase and the measurement forcing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= RFT_CTRL_RST;
    end else if (wr && paddr == RFT_CTRL_OFS) begin
      ctrl_q <= pwdata[2:0];
    end
  end

  // Link frame offset, full 8-bit range is legal
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fofs_q <= 8'h00;
    end else if (wr && paddr == RFT_FOFS_OFS) begin
      fofs_q <= pwdata[7:0];
    end
  end

  // Chip offset; out-of-range writes are dropped, old value kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cofs_q <= RFT_ZERO16;
    end else if (wr && paddr == RFT_COFS_OFS && !cofs_bad) begin
      cofs_q <= pwdata[15:0];
    end
  end

  // Default offsets; the FDD field is checked, the TDD field fits its width
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fdd_q <= 10'h000;
      tdd_q <= 3'h0;
    end else if (wr && paddr == RFT_DFLT_OFS) begin
      if (!fdd_bad) begin
        fdd_q <= pwdata[9:0];
      end
      tdd_q <= pwdata[RFT_DFLT_TDD_LSB +: 3];
    end
  end

  // Secondary common offset holds only one of four codes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scc_q <= RFT_SCC_0MS;
    end else if (wr && paddr == RFT_SCCO_OFS) begin
      scc_q <= rft_scc_e'(pwdata[1:0]);
    end
  end

  // Measurements from the terminal; the chip field is range checked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mfd_q <= 8'h00;
      mcd_q <= RFT_ZERO16;
    end else if (wr && paddr == RFT_MEAS_OFS) begin
      mfd_q <= pwdata[7:0];
      if (pwdata[RFT_MEAS_CHIP_LSB +: 16] <= RFT_CHIP_MAX) begin
        mcd_q <= pwdata[RFT_MEAS_CHIP_LSB +: 16];
      end
    end
  end

  // Sticky range error; a new error beats a clear in the same cycle
  assign err_set = wr && ((paddr == RFT_COFS_OFS && cofs_bad) ||
                          (paddr == RFT_DFLT_OFS && fdd_bad) ||
                          (paddr == RFT_MEAS_OFS &&
                           pwdata[RFT_MEAS_CHIP_LSB +: 16] > RFT_CHIP_MAX));
  assign err_clr = wr && paddr == RFT_STAT_OFS && pwdata[RFT_STAT_ERR_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_q <= 1'b0;
    end else if (err_set) begin
      err_q <= 1'b1;
    end else if (err_clr) begin
      err_q <= 1'b0;
    end
  end

  // Frame divider: one tick per 10 ms while running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= '0;
    end else if (!ctrl_q[RFT_CTRL_RUN_BIT]) begin
      div_q <= '0;
    end else if (div_q == TW'(FRAME_CYC - 1)) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  assign tick = ctrl_q[RFT_CTRL_RUN_BIT] && div_q == TW'(FRAME_CYC - 1);

  // Tick out as a registered pulse so the station side sees a clean edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_tick <= 1'b0;
    end else begin
      frame_tick <= tick;
    end
  end

  // Controller node-wide counter, fixed full range
  rft_frame_ctr #(
    .W(12)
  ) u_ctl_cnt (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .max_val(RFT_LONG_MAX),
    .count(ctl_cnt)
  );

  // Connection counter; paging mode widens its range
  assign conn_max = ctrl_q[RFT_CTRL_PCH_BIT] ? RFT_LONG_MAX : RFT_CONN_MAX;

  rft_frame_ctr #(
    .W(12)
  ) u_conn_cnt (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .max_val(conn_max),
    .count(conn_cnt)
  );

  // Dedicated channel offset derived from the chip offset
  rft_round256 u_round (
    .chips(cofs_q),
    .rounded(dch_rnd)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dch_q <= RFT_ZERO16;
    end else begin
      dch_q <= dch_rnd;
    end
  end

  // Forward measurements, forced to zero for a single link from common
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meas_q <= '0;
    end else if (ctrl_q[RFT_CTRL_ONE_BIT]) begin
      meas_q.measured_frame_difference <= 8'h00;
      meas_q.measured_chip_difference <= RFT_ZERO16;
    end else begin
      meas_q.measured_frame_difference <= mfd_q;
      meas_q.measured_chip_difference <= mcd_q;
    end
  end

  // Transport block set handshake; a write while busy is ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tb_q <= RFT_TB_IDLE;
      tbs_q <= '0;
    end else begin
      case (tb_q)
        RFT_TB_IDLE: begin
          if (wr && paddr == RFT_TBS_OFS) begin
            tbs_q.connection_frame_counter <= conn_cnt;
            tbs_q.tag <= pwdata[15:0];
            tb_q <= RFT_TB_SEND;
          end
        end
        RFT_TB_SEND: begin
          if (tbs_ready) begin
            tb_q <= RFT_TB_IDLE;
          end
        end
        default: tb_q <= RFT_TB_IDLE;
      endcase
    end
  end

  assign tbs_valid = tb_q == RFT_TB_SEND;
  assign tbs = tbs_q;
  assign meas = meas_q;

  // Offsets bundle straight from the registers
  assign offsets.link_frame_offset = fofs_q;
  assign offsets.link_chip_offset = cofs_q;
  assign offsets.dedicated_channel_frame_offset = dch_q;
  assign offsets.fdd_default_link_offset = fdd_q;
  assign offsets.tdd_default_link_offset = tdd_q;
  assign offsets.secondary_common_channel_offset = scc_q;

  // Read mux; unmapped words read as zero
  always_comb begin
    rd_d = 32'h0000_0000;
    case (paddr)
      RFT_CTRL_OFS: rd_d[2:0] = ctrl_q;
      RFT_FOFS_OFS: rd_d[7:0] = fofs_q;
      RFT_COFS_OFS: rd_d[15:0] = cofs_q;
      RFT_DFLT_OFS: begin
        rd_d[9:0] = fdd_q;
        rd_d[RFT_DFLT_TDD_LSB +: 3] = tdd_q;
      end
      RFT_SCCO_OFS: rd_d[1:0] = scc_q;
      RFT_MEAS_OFS: begin
        rd_d[7:0] = mfd_q;
        rd_d[RFT_MEAS_CHIP_LSB +: 16] = mcd_q;
      end
      RFT_TBS_OFS: rd_d[15:0] = tbs_q.tag;
      RFT_STAT_OFS: begin
        rd_d[11:0] = ctl_cnt;
        rd_d[RFT_STAT_BUSY_BIT] = tb_q == RFT_TB_SEND;
        rd_d[RFT_STAT_ERR_BIT] = err_q;
        rd_d[RFT_STAT_CFN_LSB +: 12] = conn_cnt;
      end
      RFT_DCHO_OFS: rd_d[15:0] = dch_q;
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // Latch in setup so access presents flop data with no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata_q <= rd_d;
    end
  end
endmodule

// *** testbench/rft_ctrl_props.sv ***
// Port checker for the frame timing controller
`timescale 1ns/1ps
module rft_ctrl_props
  import rft_pkg::*;
#(
  parameter int FRAME_CYC = RFT_FRAME_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire rft_offsets_s offsets,
  input wire rft_meas_s meas,
  input wire logic frame_tick,
  input wire logic tbs_valid,
  input wire rft_tbs_s tbs,
  input wire logic tbs_ready
);
  logic [19:0] gap_q;
  logic seen_q;
  // Cycles since the last frame pulse; a paused divider only lengthens it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_q <= 20'h00000;
      seen_q <= 1'b0;
    end else begin
      gap_q <= frame_tick ? 20'h00000 : gap_q + 20'h00001;
      seen_q <= seen_q | frame_tick;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence wr_at(logic [7:0] a);
    psel && penable && pwrite && paddr == a;
  endsequence
  // Nearest 256-chip step, a whole frame folds to zero
  function automatic logic [15:0] rnd(logic [15:0] c);
    logic [16:0] s;
    s = {1'b0, c} + 17'h00080;
    s[7:0] = 8'h00;
    return (s[15:0] == RFT_CHIPS_PER_FRAME) ? 16'h0000 : s[15:0];
  endfunction
  lfo_take_a: assert property (wr_at(RFT_FOFS_OFS) |=>
    offsets.link_frame_offset == $past(pwdata[7:0])) else $error("frame offset not taken");
  chip_refuse_a: assert property (wr_at(RFT_COFS_OFS) ##0 pwdata[15:0] > RFT_CHIP_MAX
    |=> $stable(offsets.link_chip_offset)) else $error("bad chip offset taken");
  dch_round_a: assert property (wr_at(RFT_COFS_OFS) ##0 pwdata[15:0] <= RFT_CHIP_MAX |->
    ##3 offsets.dedicated_channel_frame_offset == rnd($past(pwdata[15:0], 3)))
    else $error("dedicated offset wrong");
  scc_take_a: assert property (wr_at(RFT_SCCO_OFS) |=>
    offsets.secondary_common_channel_offset == $past(pwdata[1:0])) else $error("scc wrong");
  tick_gap_a: assert property (frame_tick && seen_q |-> gap_q >= FRAME_CYC - 1)
    else $error("frame pulses too close");
  tbs_launch_a: assert property (wr_at(RFT_TBS_OFS) ##0 !tbs_valid |=>
    tbs_valid && tbs.tag == $past(pwdata[15:0])) else $error("transfer not launched");
  tbs_hold_a: assert property (tbs_valid && !tbs_ready |=> tbs_valid && $stable(tbs))
    else $error("transfer dropped early");
  tbs_drop_a: assert property (tbs_valid && tbs_ready |=> !tbs_valid)
    else $error("transfer held after accept");
endmodule
bind rft_ctrl rft_ctrl_props #(.FRAME_CYC(FRAME_CYC)) i_rft_ctrl_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .offsets(offsets), .meas(meas), .frame_tick(frame_tick), .tbs_valid(tbs_valid),
  .tbs(tbs), .tbs_ready(tbs_ready));

// *** testbench/rft_station_model.sv ***
// Behavioural base station fed by the controller
`timescale 1ns/1ps
module rft_station_model
  import rft_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire rft_offsets_s offsets,
  input wire logic frame_tick,
  input wire logic tbs_valid,
  input wire rft_tbs_s tbs,
  input wire logic [3:0] ready_dly,
  output logic tbs_ready,
  output logic [31:0] air_chips,
  output logic [7:0] tx_frame,
  output logic [7:0] rx_cfn,
  output rft_tbs_s got_tbs,
  output logic [7:0] n_tbs
);
  logic [11:0] node_q;
  logic [3:0] wait_q;
  logic [31:0] sum;
  // Node count locked to the controller pulse; 12 bits wrap after 4095
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) node_q <= 12'h000;
    else if (frame_tick) node_q <= node_q + 12'h001;
  end
  // Cell frame number is the node count minus the link frame offset, low 8 bits
  assign rx_cfn = node_q[7:0] - offsets.link_frame_offset;
  // Air timing on a 256-chip grid whatever the spreading factor
  always_comb begin
    sum = 32'(offsets.link_frame_offset) * 32'h00009600 + 32'(offsets.link_chip_offset);
    if (sum[7:0] == 8'h00) air_chips = sum;
    else if (!sum[7]) air_chips = {sum[31:8], 8'h00};
    else air_chips = {sum[31:8] + 24'h000001, 8'h00};
  end
  // Accept after ready_dly cycles, one-cycle ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tbs_ready <= 1'b0;
      wait_q <= 4'h0;
      n_tbs <= 8'h00;
      got_tbs <= '0;
      tx_frame <= 8'h00;
    end else if (tbs_valid && tbs_ready) begin
      tbs_ready <= 1'b0;
      got_tbs <= tbs;
      n_tbs <= n_tbs + 8'h01;
      tx_frame <= tbs.connection_frame_counter[7:0] + offsets.link_frame_offset;
    end else if (!tbs_valid) begin
      tbs_ready <= 1'b0;
      wait_q <= 4'h0;
    end else if (wait_q == ready_dly) tbs_ready <= 1'b1;
    else wait_q <= wait_q + 4'h1;
  end
endmodule

// *** testbench/rft_ctrl_test.sv ***
// Self-checking bench for the frame timing controller
`timescale 1ns/1ps
module rft_ctrl_test;
  import rft_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, frame_tick, tbs_valid, tbs_ready;
  logic er;
  logic [7:0] paddr, txf, ntb, rxc;
  logic [31:0] pwdata, prdata, rd, air, s, e, ce;
  logic [3:0] dly;
  logic [15:0] cv[6] = '{16'h0000, 16'h007F, 16'h0080, 16'h0200, 16'h94FF, 16'h95FF};
  logic [15:0] dv[6] = '{16'h0000, 16'h0000, 16'h0100, 16'h0200, 16'h9500, 16'h0000};
  rft_offsets_s offsets;
  rft_meas_s meas;
  rft_tbs_s tbs, got;
  int n_fail, checked, ticks, t0;
  rft_ctrl #(.FRAME_CYC(8)) i_rft_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .offsets(offsets), .meas(meas),
    .frame_tick(frame_tick), .tbs_valid(tbs_valid), .tbs(tbs), .tbs_ready(tbs_ready));
  rft_station_model i_rft_station_model (.pclk(pclk), .presetn(presetn), .offsets(offsets),
    .frame_tick(frame_tick), .tbs_valid(tbs_valid), .tbs(tbs), .ready_dly(dly),
    .tbs_ready(tbs_ready), .air_chips(air), .tx_frame(txf), .rx_cfn(rxc), .got_tbs(got),
    .n_tbs(ntb));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // Frame pulses seen so far
  always @(posedge pclk) if (frame_tick === 1'b1) ticks <= ticks + 1;
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer; waits on pready, never on a fixed count
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task halt();
    xfer(1'b1, RFT_CTRL_OFS, 32'h0);
    repeat (3) @(posedge pclk);
    xfer(1'b0, RFT_STAT_OFS, 32'h0);
  endtask
  task summarize();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge pclk);
    n_fail++;
    summarize();
  end
  initial begin
    {n_fail, checked, ticks} = '0;
    {presetn, psel, penable, pwrite, paddr, pwdata, dly} = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset contents, then one unmapped word
    for (int a = 0; a <= 36; a += 4) begin
      xfer(1'b0, 8'(a), 32'h0);
      chk("reset", rd, 32'h0);
      chk("slverr", {31'h0, er}, {31'h0, a == 36});
    end
    xfer(1'b1, RFT_FOFS_OFS, 32'h000000FF);
    chk("lfo", {24'h0, offsets.link_frame_offset}, 32'hFF);
    // Chip offsets around the 0x80 rounding threshold and the whole-frame fold
    foreach (cv[i]) begin
      xfer(1'b1, RFT_COFS_OFS, {16'h0, cv[i]});
      repeat (3) @(posedge pclk);
      xfer(1'b0, RFT_DCHO_OFS, 32'h0);
      chk("dch", rd, {16'h0, dv[i]});
      s = 32'h000000FF * 32'h00009600 + {16'h0, cv[i]};
      e = (s[7:0] == 8'h0) ? s : s[7] ? {s[31:8] + 24'h1, 8'h0} : {s[31:8], 8'h0};
      chk("air", air, e);
    end
    xfer(1'b1, RFT_COFS_OFS, 32'h00009600);
    chk("cofs kept", {16'h0, offsets.link_chip_offset}, 32'h95FF);
    xfer(1'b0, RFT_STAT_OFS, 32'h0);
    chk("err", {31'h0, rd[RFT_STAT_ERR_BIT]}, 32'h1);
    xfer(1'b1, RFT_DFLT_OFS, 32'h00070257);
    xfer(1'b1, RFT_DFLT_OFS, 32'h00030258);
    chk("fdd", {22'h0, offsets.fdd_default_link_offset}, 32'h257);
    chk("tdd", {29'h0, offsets.tdd_default_link_offset}, 32'h3);
    for (int c = 0; c < 4; c++) begin
      xfer(1'b1, RFT_SCCO_OFS, 32'(c));
      chk("scc", {30'h0, offsets.secondary_common_channel_offset}, 32'(c));
    end
    xfer(1'b1, RFT_MEAS_OFS, 32'h95FF00FF);
    xfer(1'b1, RFT_MEAS_OFS, 32'h96000012);
    // Forwarded measurements trail the register by one edge
    @(posedge pclk);
    chk("meas", {8'h0, meas}, 32'h001295FF);
    xfer(1'b1, RFT_CTRL_OFS, 32'h4);
    @(posedge pclk);
    chk("meas one", {8'h0, meas}, 32'h0);
    // Paging range past 4095, then connection range past 255
    xfer(1'b1, RFT_CTRL_OFS, 32'h3);
    while (ticks < 4100) @(posedge pclk);
    halt();
    chk("ctl cnt", {20'h0, rd[11:0]}, 32'(ticks % 4096));
    chk("pch cnt", {20'h0, rd[31:20]}, 32'(ticks % 4096));
    t0 = ticks;
    repeat (20) @(posedge pclk);
    chk("held", 32'(ticks), 32'(t0));
    xfer(1'b1, RFT_CTRL_OFS, 32'h1);
    while (ticks < t0 + 260) @(posedge pclk);
    halt();
    ce = 32'(ticks % 256);
    chk("conn cnt", {20'h0, rd[31:20]}, ce);
    chk("rx cfn", {24'h0, rxc}, (32'(ticks) + 32'h1) & 32'hFF);
    // Slow station, second launch while busy is dropped
    dly <= 4'hC;
    xfer(1'b1, RFT_TBS_OFS, 32'h1234);
    xfer(1'b0, RFT_STAT_OFS, 32'h0);
    chk("busy", {31'h0, rd[RFT_STAT_BUSY_BIT]}, 32'h1);
    xfer(1'b1, RFT_TBS_OFS, 32'h5678);
    repeat (20) @(posedge pclk);
    chk("tbs n", {24'h0, ntb}, 32'h1);
    chk("tbs tag", {16'h0, got.tag}, 32'h1234);
    chk("tbs cfn", {20'h0, got.connection_frame_counter}, ce);
    chk("tx frame", {24'h0, txf}, (ce + 32'hFF) & 32'hFF);
    dly <= 4'h0;
    xfer(1'b1, RFT_TBS_OFS, 32'hABCD);
    repeat (5) @(posedge pclk);
    chk("tbs n2", {24'h0, ntb}, 32'h2);
    chk("tbs tag2", {16'h0, got.tag}, 32'hABCD);
    summarize();
  end
endmodule
